// ### rtl/cbt_bit_timer.sv
// bit timing engine: segments, sampling, hard sync and resync
// assumes rx is synchronous to aclk and tq_tick is one cycle per quantum
`timescale 1ns/1ps
module cbt_bit_timer import cbt_pkg::*; (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire logic     tq_tick,
  input  wire logic     rx,
  input  wire logic     hs_en,
  input  wire logic     tx_active,
  input  wire cbt_cfg_s cfg,
  output logic          sample_pulse,
  output logic          rx_bit,
  output logic          bit_start,
  output logic          hard_sync
);

  cbt_seg_e   st_r;
  logic [4:0] cnt_r;
  logic [2:0] ext_r;
  logic [2:0] shr_r;
  logic       rs_done_r;
  logic       rx_prev_r;
  logic       rx_bit_r;
  logic       sample_r;
  logic       bstart_r;

  // =====================================================
  // edge classification
  logic       fall;
  logic       chg;
  logic       resync;
  logic [4:0] ts1_last;
  logic       ts1_end;
  logic       ts2_end;
  logic [4:0] err_pos;
  logic [4:0] err_neg;
  logic [2:0] ext_new;
  logic       neg_small;

  assign fall      = rx_prev_r & ~rx;
  assign chg       = rx_prev_r ^ rx;
  assign hard_sync = fall & hs_en;
  // transmit timing never follows other nodes
  assign resync    = chg & ~hs_en & ~tx_active & rx_bit_r & ~rs_done_r;
  assign ts1_last  = 5'(cfg.ts1_len + 5'(ext_r) - 5'd1);
  assign ts1_end   = (cnt_r == ts1_last);
  assign ts2_end   = (5'(cnt_r + 5'(shr_r)) >= 5'(cfg.ts2_len - 4'd1));
  assign err_pos   = 5'(cnt_r + 5'd1);
  assign err_neg   = 5'(5'(cfg.ts2_len) - cnt_r);
  assign ext_new   = (err_pos < 5'(cfg.sjw)) ? err_pos[2:0] : cfg.sjw;
  assign neg_small = (err_neg <= 5'(cfg.sjw));

  assign sample_pulse = sample_r;
  assign rx_bit       = rx_bit_r;
  assign bit_start    = bstart_r;

  // =====================================================
  // segment sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= ST_SYNC;
      cnt_r     <= 5'h00;
      ext_r     <= 3'h0;
      shr_r     <= 3'h0;
      rs_done_r <= 1'b0;
      rx_prev_r <= 1'b1;
      rx_bit_r  <= 1'b1;
      sample_r  <= 1'b0;
      bstart_r  <= 1'b0;
    end else begin
      rx_prev_r <= rx;
      sample_r  <= 1'b0;
      bstart_r  <= 1'b0;
      if (hard_sync) begin
        st_r      <= ST_SYNC;
        cnt_r     <= 5'h00;
        ext_r     <= 3'h0;
        shr_r     <= 3'h0;
        rs_done_r <= 1'b1;
        bstart_r  <= 1'b1;
      end else if (resync && st_r == ST_TS1) begin
        ext_r     <= ext_new;
        rs_done_r <= 1'b1;
      end else if (resync && st_r == ST_TS2) begin
        rs_done_r <= ~neg_small;
        if (neg_small) begin
          st_r     <= ST_SYNC;
          cnt_r    <= 5'h00;
          bstart_r <= 1'b1;
        end else begin
          shr_r <= cfg.sjw;
        end
      end else if (tq_tick) begin
        unique case (st_r)
          ST_SYNC: begin
            st_r  <= ST_TS1;
            cnt_r <= 5'h00;
          end
          ST_TS1: begin
            if (ts1_end) begin
              st_r     <= ST_TS2;
              cnt_r    <= 5'h00;
              sample_r <= 1'b1;
              rx_bit_r <= rx;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
          ST_TS2: begin
            if (ts2_end) begin
              st_r      <= ST_SYNC;
              cnt_r     <= 5'h00;
              ext_r     <= 3'h0;
              shr_r     <= 3'h0;
              rs_done_r <= 1'b0;
              bstart_r  <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
        endcase
      end
    end
  end

endmodule

// ### rtl/cbt_defs.svh
// constants for the bit-timing and bus-off recovery block
// assumes an AXI4-Lite slave with 32-bit data and word-aligned registers
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH

// register byte offsets
`define CBT_OFS_CTRL        8'h00
`define CBT_OFS_INFO        8'h04
`define CBT_OFS_ERC         8'h08
`define CBT_OFS_BRP         8'h0C
`define CBT_OFS_BTR         8'h10

// module_control_reg fields
`define CBT_CTRL_MODE_LSB   0
`define CBT_CTRL_MODE_MSB   2
`define CBT_CTRL_CCE_BIT    3
`define CBT_CTRL_PEND_BIT   8

// module_info_reg fields
`define CBT_INFO_JOINW_BIT  0
`define CBT_INFO_BOFF_BIT   4

// bit-rate register fields
`define CBT_BTR_TS1_LSB     0
`define CBT_BTR_TS1_MSB     3
`define CBT_BTR_TS2_LSB     8
`define CBT_BTR_TS2_MSB     10
`define CBT_BTR_SJW_LSB     12
`define CBT_BTR_SJW_MSB     13

// reset values
`define CBT_BRP_RST         8'hFF
`define CBT_BTR_RST         16'h370F
`define CBT_MODE_INIT       3'h0

// recovery counts
`define CBT_IDLE_BITS       4'hB
`define CBT_RECOVERY_COUNT  8'h80

// AXI responses
`define CBT_RESP_OKAY       2'h0
`define CBT_RESP_SLVERR     2'h2

`endif

// ### rtl/cbt_pkg.sv
// types shared by the bit-timing and bus-off recovery block
// assumes cbt_defs.svh carries all numeric constants
package cbt_pkg;

  // segment lengths in time quanta, already decoded from the bit-rate register
  typedef struct packed {
    logic [4:0] ts1_len;
    logic [3:0] ts2_len;
    logic [2:0] sjw;
  } cbt_cfg_s;

  typedef enum logic [1:0] {
    ST_SYNC,
    ST_TS1,
    ST_TS2
  } cbt_seg_e;

endpackage

// ### rtl/cbt_prescaler.sv
// time-quantum prescaler
// assumes brp holds the division ratio minus one
`timescale 1ns/1ps
module cbt_prescaler import cbt_pkg::*; (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] brp,
  input  wire logic       restart,
  output logic            tq_tick
);

  logic [7:0] cnt_r;
  logic       last;

  // =====================================================
  // divider
  assign last    = (cnt_r == brp);
  assign tq_tick = last & ~restart;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h00;
    end else if (restart || last) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule

// ### rtl/cbt_top.sv
// CAN bit timing and bus-off recovery controller with AXI4-Lite registers
// assumes an external transceiver on can_tx/can_rx and a protocol layer
// that reports bus-off entry, transmit activity and interframe space
//
// How it works
// - forced bus-off exit works whatever the bus does: init request, then operation request with clear_error_counters
// - that combined request skips the recovery sequence and enters the mode at once
// - after a forced exit the node joins only after 11 recessive bits
// - clear_error_counters in init resets the error register and the info bus-off bit (not the join-wait bit), then reads zero
// - clear_error_counters in an operation mode leaves both registers untouched
// - a bit is sync quantum, then segment one, then segment two; 8 to 25 quanta (the segment ranges allow 4 to 25)
// - segment one is propagation plus phase one; segment two is phase two
// - segment one spans 2 to 16 quanta
// - segment two spans 1 to 8 quanta; keep it below segment one
// - no processing quanta after the sample point
// - jump width spans 1 to 4 quanta
// - falling edge in interframe space hard-syncs: edge quantum becomes sync
// - resync during reception only when the last sampled bit was recessive
// - phase error zero in sync, positive before, negative after the sample point
// - positive error stretches phase one, negative shrinks phase two, by jump width
// - a transmitter keeps its own timing and never resyncs
// - normal recovery holds the mode request until 128 runs of 11 recessive bits
// - an init request is taken at once and the mode field reads 000
// - while bus-off the transmit pin stays recessive
`timescale 1ns/1ps
`include "cbt_defs.svh"
module cbt_top import cbt_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        can_rx,
  output logic             can_tx,
  input  wire logic        tx_bit,
  input  wire logic        tx_active,
  input  wire logic        bus_idle,
  input  wire logic        busoff_enter,
  output logic             sample_pulse,
  output logic             rx_bit,
  output logic             bit_start,
  output logic             bus_joined
);

  // =====================================================
  // register state
  logic [2:0]  mode_r;
  logic        pend_r;
  logic [2:0]  req_mode_r;
  logic        busoff_r;
  logic [7:0]  rec_r;
  logic        join_wait_r;
  logic [3:0]  run_r;
  logic [7:0]  brp_r;
  logic [15:0] btr_r;
  logic        tx_r;

  // =====================================================
  // AXI write channel
  logic        aw_held_r;
  logic [7:0]  aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        wr_fire;
  logic        wr_hit_ctrl;
  logic        wr_hit_brp;
  logic        wr_hit_btr;
  logic        wr_mapped;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_fire       = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_hit_ctrl   = wr_fire & (aw_addr_r == `CBT_OFS_CTRL);
  assign wr_hit_brp    = wr_fire & (aw_addr_r == `CBT_OFS_BRP);
  assign wr_hit_btr    = wr_fire & (aw_addr_r == `CBT_OFS_BTR);
  assign wr_mapped     = (aw_addr_r == `CBT_OFS_CTRL) | (aw_addr_r == `CBT_OFS_INFO) |
                         (aw_addr_r == `CBT_OFS_ERC) | (aw_addr_r == `CBT_OFS_BRP) |
                         (aw_addr_r == `CBT_OFS_BTR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `CBT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? `CBT_RESP_OKAY : `CBT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // =====================================================
  // control write decode
  logic       in_init;
  logic       ctrl_we;
  logic [2:0] wr_mode;
  logic       wr_cce;
  logic       req_init;
  logic       req_op;
  logic       forced_exit;
  logic       clr_counters;
  logic       cfg_we;

  assign in_init      = (mode_r == `CBT_MODE_INIT);
  assign ctrl_we      = wr_hit_ctrl & w_strb_r[0];
  assign wr_mode      = w_data_r[`CBT_CTRL_MODE_MSB:`CBT_CTRL_MODE_LSB];
  assign wr_cce       = w_data_r[`CBT_CTRL_CCE_BIT];
  assign req_init     = ctrl_we & (wr_mode == `CBT_MODE_INIT);
  assign req_op       = ctrl_we & (wr_mode != `CBT_MODE_INIT) & in_init;
  // combined operation request and clear from init skips recovery
  assign forced_exit  = req_op & wr_cce & busoff_r;
  assign clr_counters = ctrl_we & wr_cce & in_init;
  assign cfg_we       = in_init;

  // =====================================================
  // bit-rate configuration, writable in init only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brp_r <= `CBT_BRP_RST;
    end else if (wr_hit_brp && w_strb_r[0] && cfg_we) begin
      brp_r <= w_data_r[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btr_r <= `CBT_BTR_RST;
    end else if (wr_hit_btr && cfg_we) begin
      if (w_strb_r[0]) btr_r[7:0] <= w_data_r[7:0];
      if (w_strb_r[1]) btr_r[15:8] <= w_data_r[15:8];
    end
  end

  // segment one code 0 would give one quantum, so it is lifted to two
  logic [3:0] ts1_code;
  cbt_cfg_s   cfg;

  assign ts1_code    = btr_r[`CBT_BTR_TS1_MSB:`CBT_BTR_TS1_LSB];
  assign cfg.ts1_len = (ts1_code == 4'h0) ? 5'd2 : 5'({1'b0, ts1_code} + 5'd1);
  assign cfg.ts2_len = 4'({1'b0, btr_r[`CBT_BTR_TS2_MSB:`CBT_BTR_TS2_LSB]} + 4'd1);
  assign cfg.sjw     = 3'({1'b0, btr_r[`CBT_BTR_SJW_MSB:`CBT_BTR_SJW_LSB]} + 3'd1);

  // =====================================================
  // bit timing
  logic tq_tick;
  logic hard_sync;

  cbt_prescaler u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .brp     (brp_r),
    .restart (hard_sync),
    .tq_tick (tq_tick)
  );

  cbt_bit_timer u_timer (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .tq_tick      (tq_tick),
    .rx           (can_rx),
    .hs_en        (bus_idle),
    .tx_active    (tx_active),
    .cfg          (cfg),
    .sample_pulse (sample_pulse),
    .rx_bit       (rx_bit),
    .bit_start    (bit_start),
    .hard_sync    (hard_sync)
  );

  // =====================================================
  // recessive run detection
  logic run_done;

  assign run_done = sample_pulse & rx_bit & (run_r == 4'(`CBT_IDLE_BITS - 4'h1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 4'h0;
    end else if (sample_pulse || req_op) begin
      run_r <= (req_op || !rx_bit || run_done) ? 4'h0 : run_r + 4'h1;
    end
  end

  // =====================================================
  // mode and bus-off control
  logic       rec_full;
  logic [7:0] rec_inc;

  assign rec_inc  = rec_r + 8'h01;
  assign rec_full = pend_r & run_done & (rec_inc == `CBT_RECOVERY_COUNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r      <= `CBT_MODE_INIT;
      pend_r      <= 1'b0;
      req_mode_r  <= `CBT_MODE_INIT;
      busoff_r    <= 1'b0;
      rec_r       <= 8'h00;
      join_wait_r <= 1'b0;
    end else begin
      if (req_init) begin
        mode_r <= `CBT_MODE_INIT;
        pend_r <= 1'b0;
      end else if (forced_exit) begin
        mode_r      <= wr_mode;
        busoff_r    <= 1'b0;
        rec_r       <= 8'h00;
        join_wait_r <= 1'b1;
      end else if (req_op && busoff_r) begin
        pend_r     <= 1'b1;
        req_mode_r <= wr_mode;
        rec_r      <= 8'h00;
      end else if (ctrl_we) begin
        mode_r <= wr_mode;
      end else if (rec_full) begin
        mode_r   <= req_mode_r;
        pend_r   <= 1'b0;
        busoff_r <= 1'b0;
        rec_r    <= 8'h00;
      end else if (pend_r && run_done) begin
        rec_r <= rec_inc;
      end
      if (clr_counters && !forced_exit) begin
        rec_r    <= 8'h00;
        busoff_r <= 1'b0;
        pend_r   <= 1'b0;
      end
      if (join_wait_r && run_done) begin
        join_wait_r <= 1'b0;
      end
      if (busoff_enter) begin
        busoff_r    <= 1'b1;
        pend_r      <= 1'b0;
        join_wait_r <= 1'b0;
      end
    end
  end

  // =====================================================
  // transmit pin
  logic tx_cut;

  assign tx_cut     = busoff_r | in_init | join_wait_r;
  assign bus_joined = ~tx_cut;
  assign can_tx     = tx_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_r <= 1'b1;
    end else begin
      tx_r <= tx_cut ? 1'b1 : tx_bit;
    end
  end

  // =====================================================
  // AXI read channel
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  rd_addr;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_info;
  logic [31:0] rd_mux;
  logic        rd_mapped;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign rd_addr       = {s_axi_araddr[7:2], 2'b00};
  // clear_error_counters always reads back zero
  assign rd_ctrl       = {23'h0, pend_r, 5'h00, mode_r};
  assign rd_info       = {27'h0, busoff_r, 3'h0, join_wait_r};
  assign rd_mapped     = (rd_addr == `CBT_OFS_CTRL) | (rd_addr == `CBT_OFS_INFO) |
                         (rd_addr == `CBT_OFS_ERC) | (rd_addr == `CBT_OFS_BRP) |
                         (rd_addr == `CBT_OFS_BTR);
  assign rd_mux        = (rd_addr == `CBT_OFS_CTRL) ? rd_ctrl :
                         (rd_addr == `CBT_OFS_INFO) ? rd_info :
                         (rd_addr == `CBT_OFS_ERC)  ? {25'h0, rec_r[6:0]} :
                         (rd_addr == `CBT_OFS_BRP)  ? {24'h0, brp_r} :
                         (rd_addr == `CBT_OFS_BTR)  ? {16'h0, btr_r} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `CBT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_mapped ? `CBT_RESP_OKAY : `CBT_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// ### tb/cbt_bus_node.sv
// far-side model: the other nodes on the wired-AND bus behind the transceiver
// assumes the bench raises dom whenever another node is to drive dominant
`timescale 1ns/1ps
module cbt_bus_node import cbt_pkg::*; (
  input  wire logic dom,
  input  wire logic can_tx,
  output logic      can_rx
);
  // =====================================
  // bus level
  // pull-up gives recessive unless any node drives dominant
  assign can_rx = can_tx & ~dom;
endmodule

// ### tb/cbt_checker.sv
// assertions on the ports of the bit-timing and bus-off recovery block
// assumes it is bound into cbt_top and sees its ports by name
`timescale 1ns/1ps
module cbt_checker import cbt_pkg::*; (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        can_tx,
  input wire logic        tx_bit,
  input wire logic        busoff_enter,
  input wire logic        sample_pulse,
  input wire logic        rx_bit,
  input wire logic        bit_start,
  input wire logic        bus_joined
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // =====================================
  // register bus
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  // =====================================
  // bus pin and bit timing
  tx_quiet_a: assert property (!bus_joined |=> can_tx)
    else $error("transmit not recessive while detached");
  busoff_cut_a: assert property (busoff_enter |=> !bus_joined)
    else $error("still joined after bus-off");
  tx_follow_a: assert property (bus_joined && !busoff_enter |=> can_tx == $past(tx_bit))
    else $error("transmit pin does not follow its bit");
  sample_once_a: assert property (sample_pulse |=> !sample_pulse)
    else $error("sample pulse too long");
  seg_order_a: assert property (bit_start |=> !sample_pulse [*2])
    else $error("sample inside sync segment");
  rx_at_sample_a: assert property ($changed(rx_bit) |-> sample_pulse || $past(sample_pulse))
    else $error("received bit moved off the sample point");
  cover property ($rose(bus_joined));
  cover property (sample_pulse && !rx_bit);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind cbt_top cbt_checker i_chk (.*);

// ### tb/testbench.sv
// self-checking bench for the bit-timing and bus-off recovery block
// assumes cbt_top, cbt_bus_node and the bound checker are compiled first
`timescale 1ns/1ps
`include "cbt_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench import cbt_pkg::*; ;
  logic        aclk = 1'h0, aresetn = 1'h0, dom = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        tx_bit = 1'h1, tx_active = 1'h0, bus_idle = 1'h0, busoff_enter = 1'h0;
  logic        can_rx, can_tx, sample_pulse, rx_bit, bit_start, bus_joined;
  int          error_cnt = 0, checks = 0, p, s, s0, s1;
  logic [31:0] brp_tab [4] = '{32'h0000_00FF, 32'h0000_0002, 32'h0000_0000, 32'h0000_0000};
  logic [31:0] btr_tab [4] = '{32'h0000_1203, 32'h0000_1203, 32'h0000_170F, 32'h0000_1203};
  int          len_tab [4] = '{8, 8, 25, 8};

  always #2 aclk = ~aclk;

  cbt_top i_dut (.*);
  cbt_bus_node i_node (.dom(dom), .can_tx(can_tx), .can_rx(can_rx));

  // =====================================
  // access tasks
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
    end
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (w && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
      if (!w && s_axi_rvalid) begin
        {r, q} = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `CBT_RESP_OKAY);
    acc(1'h1, a, d);
    `CHK(r, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `CBT_RESP_OKAY);
    acc(1'h0, a, 32'h0000_0000);
    `CHK({r, q}, {er, e})
  endtask

  // one bit from a sync segment to the next; optional bus change k cycles in
  task automatic meas(input int k = 0, input logic v = 1'h0);
    while (!bit_start) @(posedge aclk);
    p = 0;
    s = 0;
    do begin
      @(posedge aclk);
      p++;
      if (p == k) dom <= v;
      if (sample_pulse && s == 0) s = p;
    end while (!bit_start && p < 3000);
    if (p >= 3000) error_cnt++;
  endtask

  task automatic pulse_bo();
    busoff_enter <= 1'h1;
    @(posedge aclk);
    busoff_enter <= 1'h0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    results();
  end

  // =====================================
  // tests
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`CBT_OFS_CTRL, 32'h0000_0000);
    rd(`CBT_OFS_BRP, 32'h0000_00FF);
    rd(`CBT_OFS_BTR, 32'h0000_370F);
    rd(`CBT_OFS_INFO, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000, `CBT_RESP_SLVERR);
    wr(8'h14, 32'h0000_0000, `CBT_RESP_SLVERR);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      wr(`CBT_OFS_BRP, brp_tab[i]);
      wr(`CBT_OFS_BTR, btr_tab[i]);
      rd(`CBT_OFS_BTR, btr_tab[i]);
      meas();
      meas();
      `CHK(p, (brp_tab[i] + 1) * len_tab[i])
      if (i == 2) s0 = s;
      if (i == 3) `CHK(s0 - s, 12)
    end
    s1 = s;
    $display("bit timing done");
    meas(1, 1'h1);
    `CHK(p inside {[9:11]}, 1'h1)
    meas();
    meas(1, 1'h0);
    `CHK(p, 8)
    meas();
    meas(4, 1'h1);
    `CHK(p inside {[5:7]}, 1'h1)
    meas(1, 1'h0);
    meas();
    tx_active <= 1'h1;
    meas(1, 1'h1);
    `CHK(p, 8)
    tx_active <= 1'h0;
    meas(1, 1'h0);
    bus_idle <= 1'h1;
    meas(2, 1'h1);
    `CHK(p inside {[3:5]}, 1'h1)
    bus_idle <= 1'h0;
    meas();
    `CHK(s, s1)
    `CHK(rx_bit, 1'h0)
    $display("synchronisation done");
    pulse_bo();
    rd(`CBT_OFS_INFO, 32'h0000_0010);
    wr(`CBT_OFS_CTRL, 32'h0000_0008);
    rd(`CBT_OFS_INFO, 32'h0000_0000);
    rd(`CBT_OFS_ERC, 32'h0000_0000);
    rd(`CBT_OFS_CTRL, 32'h0000_0000);
    pulse_bo();
    wr(`CBT_OFS_CTRL, 32'h0000_0000);
    wr(`CBT_OFS_CTRL, 32'h0000_0009);
    rd(`CBT_OFS_CTRL, 32'h0000_0001);
    rd(`CBT_OFS_INFO, 32'h0000_0001);
    repeat (200) @(posedge aclk);
    `CHK(bus_joined, 1'h0)
    while (!sample_pulse) @(posedge aclk);
    dom <= 1'h0;
    p = 0;
    do begin
      @(posedge aclk);
      if (sample_pulse) p++;
    end while (!bus_joined && p < 20);
    `CHK(p, 11)
    tx_bit <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK(can_tx, 1'h0)
    tx_bit <= 1'h1;
    pulse_bo();
    rd(`CBT_OFS_INFO, 32'h0000_0010);
    wr(`CBT_OFS_CTRL, 32'h0000_0009);
    rd(`CBT_OFS_INFO, 32'h0000_0010);
    $display("forced exit done");
    wr(`CBT_OFS_CTRL, 32'h0000_0000);
    wr(`CBT_OFS_CTRL, 32'h0000_0001);
    rd(`CBT_OFS_CTRL, 32'h0000_0100);
    p = 0;
    while (!bus_joined && p < 20000) begin
      @(posedge aclk);
      p++;
    end
    `CHK(p inside {[11230:11280]}, 1'h1)
    rd(`CBT_OFS_CTRL, 32'h0000_0001);
    $display("normal recovery done");
    results();
  end
endmodule
